// ==== core/bcd_on_delay_timer_bank.sv ====
// Summary of operation
// RULE1: 512 numbers, each flag bit and present value.
// RULE2: Program defines each number only once.
// RULE3: Bit read returns the completion flag.
// RULE4: Word read returns the present value.
// RULE5: Program supplies set values in BCD.
// RULE6: Four BCD digits, zero to 999.9 seconds.
// RULE7: Zero set value completes at once.
// RULE8: Expiry up to one tenth early.
// RULE9: Program should use 0002 to 9999.
// RULE10: Condition on starts; off reloads, clears flag.
// RULE11: Decrement once per tenth second.
// RULE12: Flag holds until condition goes off.
// RULE13: Interlock off resets the timer.
// RULE14: Power interruption resets all timers.
// RULE15: Non-BCD set value keeps running, inaccurate.
// RULE16: Non-BCD set value sets error flag.
// RULE17: Bad indirect pointer sets error flag.
// RULE18: Program should spare 000-015 for fast timers.
// RULE19: Input word follows switches only in run.
// RULE20: Shared timebase, BCD decrement with borrow.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module bcd_on_delay_timer_bank #(
  parameter int unsigned TICK_CYCLES = tenth_timer_pkg::TICK_CYCLES_DEFAULT,
  parameter int unsigned MEM_WORDS = tenth_timer_pkg::MEM_WORDS_DEFAULT
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Write address channel.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Input-mapped set value word from external switches.
  input wire logic [15:0] switch_set_value,
  // Sticky error flag.
  output logic error_flag
);
  import tenth_timer_pkg::*;

  localparam int unsigned NUM_W = $clog2(TIMER_COUNT);
  localparam int unsigned TB_W = $clog2(TICK_CYCLES + 1);

  // True when every digit of the word is 0 to 9.
  function automatic logic is_bcd(input logic [15:0] w);
    return (w[15:12] <= 4'h9) && (w[11:8] <= 4'h9) && (w[7:4] <= 4'h9) && (w[3:0] <= 4'h9);
  endfunction

  // Subtract one in BCD, borrowing from the next digit up.
  function automatic logic [15:0] bcd_dec(input logic [15:0] w);
    logic [15:0] r;
    logic borrow;
    r = w;
    borrow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (borrow) begin
        if (r[4*i +: 4] == 4'h0) begin
          r[4*i +: 4] = 4'h9;
        end else begin
          r[4*i +: 4] = r[4*i +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // Binary value of a four digit BCD word; digits widen first so no product wraps.
  function automatic logic [13:0] bcd_to_bin(input logic [15:0] w);
    return 14'(w[15:12]) * 14'd1000 + 14'(w[11:8]) * 14'd100
      + 14'(w[7:4]) * 14'd10 + 14'(w[3:0]);
  endfunction

  // Timer bank storage, one entry per timer/counter number.
  timer_entry_t bank [TIMER_COUNT];
  // One pending tenth-second step per timer, consumed at its execution.
  logic [TIMER_COUNT-1:0] tick_pend;
  // Shared free-running timebase.
  logic [TB_W-1:0] tb_count;
  logic tick;

  // Software-visible registers, plus the held switch word, which the bus cannot read or write.
  logic run_mode;
  logic [15:0] mem_word;
  logic [NUM_W-1:0] sel_num;
  logic [15:0] held_switch;

  // Write channel holding state.
  logic aw_held;
  logic w_held;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // A write commits once both halves are held and no response is waiting.
  wire logic wr_commit = aw_held && w_held && !s_axi_bvalid;
  wire logic wr_ctrl = wr_commit && (wr_addr == CTRL_OFF);
  wire logic wr_exec = wr_commit && (wr_addr == EXEC_OFF);
  wire logic wr_status = wr_commit && (wr_addr == STATUS_OFF);
  wire logic wr_ind = wr_commit && (wr_addr == IND_DATA_OFF);
  wire logic wr_sel = wr_commit && (wr_addr == SELECT_OFF);
  wire logic wr_known = wr_ctrl || wr_exec || wr_status || wr_ind || wr_sel;

  // Execute command decoding.
  wire exec_cmd_t cmd = exec_cmd_t'(wr_data);
  wire timer_entry_t cur = bank[cmd.timer_num];
  wire logic pend = tick_pend[cmd.timer_num];
  // RULE6: four-digit BCD value
  wire logic [15:0] set_word = (cmd.src == SRC_INPUT) ? held_switch :
                               (cmd.src == SRC_INDIRECT) ? mem_word : cmd.set_value;
  // RULE17: pointer check
  wire logic ptr_bad = (cmd.src == SRC_INDIRECT) && (!is_bcd(cmd.set_value) ||
                       ({18'h0, bcd_to_bin(cmd.set_value)} >= 32'(MEM_WORDS)));
  // RULE16: set value check
  wire logic set_bad = !is_bcd(set_word);
  wire logic exec_err = wr_exec && (ptr_bad || set_bad);
  // RULE20: BCD step
  wire logic [15:0] stepped = bcd_dec(cur.present_value);
  wire logic step_now = cur.active && pend && (cur.present_value != 16'h0000);
  wire logic [15:0] run_value = step_now ? stepped : cur.present_value;

  // Next state of the addressed entry for one execution.
  timer_entry_t next_entry;
  always_comb begin
    next_entry = cur;
    if (!cmd.cond || !cmd.il_en) begin
      // RULE10: reload on off
      // RULE13: interlock reset
      next_entry.active = 1'b0;
      next_entry.done = 1'b0;
      next_entry.present_value = set_word;
    end else if (!cur.active) begin
      // RULE10: start on rising condition
      // RULE7: zero completes at once
      // RULE15: non-BCD still runs
      next_entry.active = 1'b1;
      next_entry.present_value = set_word;
      next_entry.done = (set_word == 16'h0000);
    end else begin
      // RULE11: tenth-second decrement
      // RULE12: flag held while on
      next_entry.present_value = run_value;
      next_entry.done = cur.done || (run_value == 16'h0000);
    end
  end

  // Shared timebase producing one tick per tenth second.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tb_count <= '0;
      tick <= 1'b0;
    end else begin
      // RULE20: free-running timebase
      tick <= (tb_count == TB_W'(TICK_CYCLES - 1));
      tb_count <= (tb_count == TB_W'(TICK_CYCLES - 1)) ? '0 : tb_count + 1'b1;
    end
  end

  // Pending steps: a tick sets all, an execution consumes its own.
  // The tick wins over the consume so that no step is dropped.
  // RULE8: early expiry by design
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tick_pend <= '0;
    end else if (tick) begin
      tick_pend <= '1;
    end else if (wr_exec) begin
      tick_pend[cmd.timer_num] <= 1'b0;
    end
  end

  // Timer bank update; reset clears every entry.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // RULE14: power-up clears all
      for (int i = 0; i < TIMER_COUNT; i++) begin
        bank[i] <= '{active: 1'b0, done: 1'b0, present_value: PRESENT_RESET};
      end
    end else if (wr_exec) begin
      bank[cmd.timer_num] <= next_entry;
    end
  end

  // Input-mapped set value follows the switches only in run mode.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      held_switch <= SET_RESET;
    end else if (run_mode) begin
      // RULE19: follow switches in run
      held_switch <= switch_set_value;
    end
  end

  // Sticky error flag; a new error wins over a write-one clear.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      error_flag <= 1'b0;
    end else if (exec_err) begin
      // RULE16: raise error flag
      error_flag <= 1'b1;
    end else if (wr_status && wr_strb[0] && wr_data[STATUS_ERR_BIT]) begin
      error_flag <= 1'b0;
    end
  end

  // Control, indirect data and select registers, byte lane 0 and 1 aware.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      run_mode <= 1'b0;
      mem_word <= SET_RESET;
      sel_num <= '0;
    end else begin
      if (wr_ctrl && wr_strb[0]) begin
        run_mode <= wr_data[CTRL_RUN_BIT];
      end
      if (wr_ind && wr_strb[0]) begin
        mem_word[7:0] <= wr_data[7:0];
      end
      if (wr_ind && wr_strb[1]) begin
        mem_word[15:8] <= wr_data[15:8];
      end
      if (wr_sel && wr_strb[0]) begin
        sel_num[7:0] <= wr_data[7:0];
      end
      if (wr_sel && wr_strb[1]) begin
        sel_num[NUM_W-1] <= wr_data[8];
      end
    end
  end

  // Write address and data are taken independently, in either order.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      // Ready is a registered offer; it drops the cycle a beat is taken.
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end else if (wr_commit) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end else if (wr_commit) begin
        w_held <= 1'b0;
      end
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Write response follows the commit by one edge.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data selection.
  wire timer_entry_t sel_entry = bank[sel_num];
  wire logic rd_take = s_axi_arvalid && s_axi_arready;
  // Every aligned offset up to the present value register is mapped.
  wire logic rd_known = (s_axi_araddr <= PRESENT_OFF) && (s_axi_araddr[1:0] == 2'b00);
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      CTRL_OFF: rd_word[CTRL_RUN_BIT] = run_mode;
      STATUS_OFF: rd_word[STATUS_ERR_BIT] = error_flag;
      IND_DATA_OFF: rd_word[15:0] = mem_word;
      SELECT_OFF: rd_word[NUM_W-1:0] = sel_num;
      PRESENT_OFF: begin
        // RULE1: flag and word per number
        // RULE3: completion flag bit
        // RULE4: present value word
        rd_word[15:0] = sel_entry.present_value;
        rd_word[DONE_BIT] = sel_entry.done;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read channel: one read at a time, answered the edge after it is taken.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // bcd_on_delay_timer_bank

`default_nettype wire

// ==== core/tenth_timer_pkg.sv ====
// Shared constants and carriers for the tenth-second delay timer bank.
`default_nettype none
package tenth_timer_pkg;

  // Clock and timebase figures.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TENTH_SECOND_NS = 100000000;
  // Cycles of core_clk per tenth-second decrement step.
  localparam int unsigned TICK_CYCLES_DEFAULT = TENTH_SECOND_NS / CLK_PERIOD_NS;

  // Bank geometry.
  localparam int unsigned TIMER_COUNT = 512;
  localparam int unsigned MEM_WORDS_DEFAULT = 1000;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] EXEC_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] IND_DATA_OFF = 8'h0c;
  localparam logic [7:0] SELECT_OFF = 8'h10;
  localparam logic [7:0] PRESENT_OFF = 8'h14;

  // Field positions.
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned STATUS_ERR_BIT = 0;
  localparam int unsigned DONE_BIT = 16;

  // Reset values.
  localparam logic [15:0] PRESENT_RESET = 16'h0000;
  localparam logic [15:0] SET_RESET = 16'h0000;

  // Set value sources carried in an execute command.
  localparam logic [1:0] SRC_CONST = 2'h0;
  localparam logic [1:0] SRC_INPUT = 2'h1;
  localparam logic [1:0] SRC_INDIRECT = 2'h2;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One timer instruction execution, as written to the execute register.
  typedef struct packed {
    logic cond;
    logic il_en;
    logic [1:0] src;
    logic [2:0] unused;
    logic [8:0] timer_num;
    logic [15:0] set_value;
  } exec_cmd_t;

  // State held for each timer/counter number.
  typedef struct packed {
    logic active;
    logic done;
    logic [15:0] present_value;
  } timer_entry_t;

endpackage
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tenth_timer_pkg::*;
  // Short tick keeps the run brief.
  localparam int unsigned TICKS = 20;
  logic core_clk;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [15:0] switch_set_value = 16'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, error_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int error_cnt = 0;
  int compares = 0;
  bcd_on_delay_timer_bank #(.TICK_CYCLES(TICKS)) dut (.core_clk, .rstn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .switch_set_value, .error_flag);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A hung handshake counts as a mismatch and ends the run.
  task automatic timed_out(input int n);
    if (n >= 100) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
  endtask
  // Leading edge keeps two drives of one signal out of one time step.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    timed_out(n);
    cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    timed_out(n);
  endtask
  task automatic run_exec(input logic c, input logic il, input logic [1:0] s,
                          input logic [8:0] num, input logic [15:0] sval);
    exec_cmd_t x;
    x = '{cond: c, il_en: il, src: s, unused: 3'h0, timer_num: num, set_value: sval};
    axi_wr(EXEC_OFF, x, RESP_OKAY);
  endtask
  // Flag in bit 16, present value below it.
  task automatic check_timer(input logic [8:0] num, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(SELECT_OFF, {23'h0, num}, RESP_OKAY);
    axi_rd(PRESENT_OFF, d, r);
    cmp("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    cmp("present", e, d);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    do_reset();
    cmp("err", 32'h0, {31'h0, error_flag});
    check_timer(9'h1ff, 32'h0);
    // low numbers free, no fast timer
    run_exec(1'b1, 1'b1, SRC_CONST, 9'h005, 16'h0000);
    check_timer(9'h005, 32'h10000);
    // Each execution is spaced past one tick, so it steps once.
    // BCD set values
    run_exec(1'b1, 1'b1, SRC_CONST, 9'h1ff, 16'h0010);
    for (int i = 1; i <= 12; i++) begin
      repeat (TICKS + 5) @(posedge core_clk);
      run_exec(1'b1, 1'b1, SRC_CONST, 9'h1ff, 16'h0010);
      if (i == 1) check_timer(9'h1ff, 32'h0009);
      if (i == 9) check_timer(9'h1ff, 32'h0001);
      if (i >= 11) check_timer(9'h1ff, 32'h10000);
    end
    run_exec(1'b1, 1'b0, SRC_CONST, 9'h1ff, 16'h0010);
    check_timer(9'h1ff, 32'h0010);
    run_exec(1'b1, 1'b1, SRC_CONST, 9'h1ff, 16'h0010);
    repeat (TICKS + 5) @(posedge core_clk);
    run_exec(1'b1, 1'b1, SRC_CONST, 9'h1ff, 16'h0010);
    check_timer(9'h1ff, 32'h0009);
    run_exec(1'b0, 1'b1, SRC_CONST, 9'h1ff, 16'h0010);
    check_timer(9'h1ff, 32'h0010);
    run_exec(1'b1, 1'b1, SRC_CONST, 9'h000, 16'h9999);
    check_timer(9'h000, 32'h9999);
    run_exec(1'b1, 1'b1, SRC_CONST, 9'h002, 16'h00a0);
    cmp("err", 32'h1, {31'h0, error_flag});
    check_timer(9'h002, 32'h00a0);
    axi_wr(STATUS_OFF, 32'h1, RESP_OKAY);
    cmp("err", 32'h0, {31'h0, error_flag});
    axi_wr(IND_DATA_OFF, 32'h0005, RESP_OKAY);
    run_exec(1'b1, 1'b1, SRC_INDIRECT, 9'h003, 16'h0999);
    check_timer(9'h003, 32'h0005);
    run_exec(1'b1, 1'b1, SRC_INDIRECT, 9'h006, 16'h1000);
    cmp("err", 32'h1, {31'h0, error_flag});
    axi_wr(STATUS_OFF, 32'h1, RESP_OKAY);
    // A high thousands digit must not wrap inside the pointer range test.
    run_exec(1'b1, 1'b1, SRC_INDIRECT, 9'h007, 16'h9000);
    cmp("err", 32'h1, {31'h0, error_flag});
    axi_wr(STATUS_OFF, 32'h1, RESP_OKAY);
    axi_wr(CTRL_OFF, 32'h1, RESP_OKAY);
    switch_set_value <= 16'h0123;
    run_exec(1'b1, 1'b1, SRC_INPUT, 9'h004, 16'h0000);
    check_timer(9'h004, 32'h0123);
    axi_wr(CTRL_OFF, 32'h0, RESP_OKAY);
    switch_set_value <= 16'h0456;
    run_exec(1'b0, 1'b1, SRC_INPUT, 9'h004, 16'h0000);
    check_timer(9'h004, 32'h0123);
    axi_wr(8'h18, 32'h1, RESP_SLVERR);
    axi_rd(8'h18, d, r);
    cmp("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    do_reset();
    check_timer(9'h000, 32'h0);
    give_verdict();
  end
endmodule // tb
`default_nettype wire

// ==== dv/timer_bank_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// Port-level checks on bus answers and the sticky error flag.
module timer_bank_asserts
  import tenth_timer_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Write side.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read side.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flag.
  input wire logic error_flag
);
  // All checks share one clock; reset silences them.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_w_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_w_ans: assert property (p_w_ans) else $error("write answer late");
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken during answer");
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_block: assert property (p_r_block) else $error("read taken during answer");
  property p_bad_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > PRESENT_OFF |=>
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not refused");
  property p_pv_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == PRESENT_OFF |=>
      s_axi_rresp == RESP_OKAY && s_axi_rdata[31:17] == 15'h0;
  endproperty
  a_pv_rd: assert property (p_pv_rd) else $error("present value read malformed");
  // The flag may only fall when a write commits.
  property p_err_clr;
    $fell(error_flag) |-> $rose(s_axi_bvalid);
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error flag fell on its own");
endmodule // timer_bank_asserts

bind bcd_on_delay_timer_bank timer_bank_asserts u_chk (.core_clk, .rstn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .error_flag);
`default_nettype wire
